// File: src/event_flag_bank.sv
`timescale 1ns/100ps
`include "event_irq_regs.svh"

module event_flag_bank #(
    parameter int N_EVENTS = 16
) (
    // Clock and reset.
    input  wire logic                mclk_i,
    input  wire logic                sys_rst_i,
    // Set and clear requests, one bit per event.
    input  wire logic [N_EVENTS-1:0] set_i,
    input  wire logic [N_EVENTS-1:0] clr_i,
    // Sticky flags.
    output logic      [N_EVENTS-1:0] flags_o
);

    logic [N_EVENTS-1:0] flags_r;
    logic [N_EVENTS-1:0] flags_nxt;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        flags_nxt = (flags_r & ~clr_i) | set_i;
    end

    // Flag storage.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_r <= N_EVENTS'(`RST_FLAGS);
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;

endmodule // event_flag_bank

// File: src/event_irq_enable_mask.sv
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "event_irq_regs.svh"

module event_irq_enable_mask
    import event_irq_pkg::*;
#(
    parameter int N_EVENTS = 16
) (
    // Clock and reset.
    input  wire logic                mclk_i,
    input  wire logic                sys_rst_i,
    // Register port.
    input  wire logic [11:0]         addr_i,
    input  wire logic [31:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [31:0]         rdata_o,
    // Hardware task triggers, one-cycle pulses.
    input  wire logic [N_EVENTS-1:0] task_trig_i,
    // Event pulses and interrupt line.
    output logic      [N_EVENTS-1:0] event_pulse_o,
    output logic                     irq_o
);

    // -----------------------------------------------------------------
    // Address decoding
    // -----------------------------------------------------------------

    // True when the address is one word of a sixteen-word bank.
    function automatic logic in_bank(input logic [11:0] a,
                                     input logic [11:0] base);
        logic [11:0] top;
        top = base + `OFS_BANK_SPAN;
        return (a >= base) && (a <= top) && (a[1:0] == 2'h0);
    endfunction

    // Maps an address to the register it selects.
    function automatic reg_sel_t decode_sel(input logic [11:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (in_bank(a, `OFS_TASK_BASE)) begin
            s = SEL_TASK;
        end else if (in_bank(a, `OFS_EVENT_BASE)) begin
            s = SEL_EVENT;
        end else if (a == `OFS_EN_DIRECT) begin
            s = SEL_DIRECT;
        end else if (a == `OFS_EN_SET) begin
            s = SEL_SET;
        end else if (a == `OFS_EN_CLEAR) begin
            s = SEL_CLEAR;
        end else if (a == `OFS_EVT_STATUS) begin
            s = SEL_STATUS;
        end
        return s;
    endfunction

    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    bus_req_t            req;
    reg_sel_t            sel;
    logic [3:0]          idx;
    logic [N_EVENTS-1:0] onehot;
    logic [N_EVENTS-1:0] wd_low;
    logic [N_EVENTS-1:0] trig_set;
    logic [N_EVENTS-1:0] flag_clr;
    logic                wr_direct;
    logic                wr_set;
    logic                wr_clr;
    logic [N_EVENTS-1:0] flags;
    logic [N_EVENTS-1:0] en;

    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;
    logic                irq_r;
    logic                irq_nxt;
    logic [N_EVENTS-1:0] pulse_r;
    logic [N_EVENTS-1:0] pulse_nxt;

    // -----------------------------------------------------------------
    // Write side
    // -----------------------------------------------------------------

    // Bundle the port, pick the register and form set and clear masks.
    // An index beyond the event count selects nothing, so a narrow
    // build never writes outside its flags.
    always_comb begin
        req       = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
        sel       = decode_sel(req.addr);
        idx       = req.addr[`IDX_MSB:`IDX_LSB];
        wd_low    = req.wdata[N_EVENTS-1:0];
        onehot    = '0;
        if (int'(idx) < N_EVENTS) begin
            onehot[idx] = 1'b1;
        end
        trig_set  = task_trig_i;
        if (req.wr && sel == SEL_TASK && req.wdata[`TASK_BIT]) begin
            trig_set = task_trig_i | onehot;
        end
        flag_clr  = '0;
        if (req.wr && sel == SEL_EVENT && req.wdata[`EVENT_BIT]) begin
            flag_clr = onehot;
        end else if (req.wr && sel == SEL_STATUS) begin
            flag_clr = wd_low;
        end
        wr_direct = req.wr && (sel == SEL_DIRECT);
        wr_set    = req.wr && (sel == SEL_SET);
        wr_clr    = req.wr && (sel == SEL_CLEAR);
    end

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------

    // Sticky event flags.
    event_flag_bank #(
        .N_EVENTS (N_EVENTS)
    ) u_flags (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .set_i    (trig_set),
        .clr_i    (flag_clr),
        .flags_o  (flags)
    );

    // Shared interrupt enable mask behind the three views.
    irq_mask_reg #(
        .N_EVENTS (N_EVENTS)
    ) u_mask (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .wr_direct_i(wr_direct),
        .wr_set_i   (wr_set),
        .wr_clr_i   (wr_clr),
        .wdata_i    (wd_low),
        .en_o       (en)
    );

    // -----------------------------------------------------------------
    // Read side and interrupt
    // -----------------------------------------------------------------

    // Read data stand only in the cycle after the read strobe; every
    // other cycle shows zero so a stale word is never mistaken for an
    // answer. Unmapped and task addresses read as zero.
    always_comb begin
        rdata_nxt = `RST_RDATA;
        if (req.rd) begin
            unique case (sel)
                SEL_DIRECT: rdata_nxt[N_EVENTS-1:0] = en;
                SEL_SET:    rdata_nxt[N_EVENTS-1:0] = en;
                SEL_CLEAR:  rdata_nxt[N_EVENTS-1:0] = en;
                SEL_STATUS: rdata_nxt[N_EVENTS-1:0] = flags;
                SEL_EVENT:  rdata_nxt[`EVENT_BIT] = |(flags & onehot);
                SEL_TASK:   rdata_nxt = `RST_RDATA;
                SEL_NONE:   rdata_nxt = `RST_RDATA;
            endcase
        end
        // Registering the gated flags costs the one cycle of latency and
        // keeps the line glitch free.
        irq_nxt   = |(flags & en);
        pulse_nxt = trig_set;
    end

    // Output registers.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= `RST_RDATA;
            irq_r   <= 1'b0;
            pulse_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign rdata_o       = rdata_r;
    assign irq_o         = irq_r;
    assign event_pulse_o = pulse_r;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // A flag whose enable is zero never raises the line.
    property p_irq_blocked;
        !(|(flags & en)) |=> !irq_o;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked)
        else $error("interrupt raised with no enabled flag");

    // Mask views show nothing above bit 15.
    property p_upper_zero;
        (rd_i && (sel == SEL_DIRECT || sel == SEL_SET || sel == SEL_CLEAR))
            |=> (rdata_o[31:16] == 16'h0000);
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("mask view upper bits not zero");

    // Writing ones to the set view enables those events.
    property p_set_write;
        wr_set |=> ((en & $past(wd_low)) == $past(wd_low));
    endproperty
    a_set_write: assert property (p_set_write)
        else $error("set view did not enable bits");

    // Reading the set view returns the mask.
    property p_set_read;
        (rd_i && sel == SEL_SET) |=> (rdata_o[N_EVENTS-1:0] == $past(en));
    endproperty
    a_set_read: assert property (p_set_read)
        else $error("set view read mismatch");

    // Writing ones to the clear view disables those events.
    property p_clr_write;
        wr_clr |=> ((en & $past(wd_low)) == '0);
    endproperty
    a_clr_write: assert property (p_clr_write)
        else $error("clear view did not disable bits");

    // Reading the clear view returns the mask.
    property p_clr_read;
        (rd_i && sel == SEL_CLEAR) |=> (rdata_o[N_EVENTS-1:0] == $past(en));
    endproperty
    a_clr_read: assert property (p_clr_read)
        else $error("clear view read mismatch");

    // Zero bits of set and clear writes leave the mask alone.
    property p_keep_zero;
        (wr_set || wr_clr)
            |=> ((en & ~$past(wd_low)) == ($past(en) & ~$past(wd_low)));
    endproperty
    a_keep_zero: assert property (p_keep_zero)
        else $error("zero bit of set or clear changed mask");

    // A direct write replaces the whole mask.
    property p_direct;
        wr_direct |=> (en == $past(wd_low));
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct view write not stored");

    // A task write sets its own flag in the next cycle.
    property p_trigger;
        (wr_i && sel == SEL_TASK && wdata_i[0] && (onehot != '0))
            |=> ((flags & $past(onehot)) != '0);
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("task trigger did not set its flag");

    // An enabled flag raises the line one cycle later.
    property p_irq_follow;
        (|(flags & en)) |=> irq_o;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("interrupt late after enabled flag");

    // -----------------------------------------------------------------
    // Coverage
    // -----------------------------------------------------------------
    property p_cov_irq_rise;
        $rose(irq_o);
    endproperty
    c_irq_rise: cover property (p_cov_irq_rise);

    property p_cov_set_clear;
        wr_set ##[1:5] wr_clr;
    endproperty
    c_set_clear: cover property (p_cov_set_clear);

    property p_cov_masked;
        ((trig_set & ~en) != '0) ##1 !irq_o;
    endproperty
    c_masked: cover property (p_cov_masked);

    property p_cov_set_wins;
        (trig_set & flag_clr) != '0;
    endproperty
    c_set_wins: cover property (p_cov_set_wins);

endmodule // event_irq_enable_mask

// File: src/event_irq_pkg.sv
package event_irq_pkg;

    // -----------------------------------------------------------------
    // Bus request carried as one bundle.
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    // -----------------------------------------------------------------
    // Register selected by an address.
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_TASK,
        SEL_EVENT,
        SEL_DIRECT,
        SEL_SET,
        SEL_CLEAR,
        SEL_STATUS
    } reg_sel_t;

endpackage

// File: src/event_irq_regs.svh
`ifndef EVENT_IRQ_REGS_SVH
`define EVENT_IRQ_REGS_SVH

// ---------------------------------------------------------------------
// Register offsets (byte addresses of aligned words; task and event bases open sixteen-word banks)
// ---------------------------------------------------------------------
`define ADDR_W          12
`define OFS_TASK_BASE   12'h000
`define OFS_EVENT_BASE  12'h100
`define OFS_BANK_SPAN   12'h03C
`define OFS_EN_DIRECT   12'h300
`define OFS_EN_SET      12'h304
`define OFS_EN_CLEAR    12'h308
`define OFS_EVT_STATUS  12'h30C

// ---------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------
`define TASK_BIT        0
`define EVENT_BIT       0
`define IDX_LSB         2
`define IDX_MSB         5
`define RST_ENABLE      32'h00000000
`define RST_FLAGS       32'h00000000
`define RST_RDATA       32'h00000000

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define IRQ_LATENCY_CYC 1

`endif

// File: src/irq_mask_reg.sv
`timescale 1ns/100ps
`include "event_irq_regs.svh"

module irq_mask_reg #(
    parameter int N_EVENTS = 16
) (
    // Clock and reset.
    input  wire logic                mclk_i,
    input  wire logic                sys_rst_i,
    // One-cycle write strobes of the three views.
    input  wire logic                wr_direct_i,
    input  wire logic                wr_set_i,
    input  wire logic                wr_clr_i,
    input  wire logic [N_EVENTS-1:0] wdata_i,
    // Shared enable mask.
    output logic      [N_EVENTS-1:0] en_o
);

    logic [N_EVENTS-1:0] en_r;
    logic [N_EVENTS-1:0] en_nxt;

    // All views act on the one mask; zero bits of set or clear keep it.
    always_comb begin
        en_nxt = en_r;
        if (wr_direct_i) begin
            en_nxt = wdata_i;
        end else if (wr_set_i) begin
            en_nxt = en_r | wdata_i;
        end else if (wr_clr_i) begin
            en_nxt = en_r & ~wdata_i;
        end
    end

    // Mask storage, cleared at reset.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_r <= N_EVENTS'(`RST_ENABLE);
        end else begin
            en_r <= en_nxt;
        end
    end

    assign en_o = en_r;

endmodule // irq_mask_reg

// File: verification/irq_sink_model.sv
`timescale 1ns/100ps

module irq_sink_model (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Interrupt line from the block.
    input  wire logic        irq_i,
    // Number of interrupt entries taken.
    output logic      [15:0] edges_o
);
    logic        last_r;
    logic        last_nxt;
    logic [15:0] edges_nxt;

    // A processor takes one entry per rising edge of the level line.
    // A line that rattles would show up as extra entries here.
    always_comb begin
        last_nxt  = irq_i;
        edges_nxt = edges_o + {15'h0000, irq_i & ~last_r};
    end

    // Registers of the entry counter.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_r  <= 1'b0;
            edges_o <= 16'h0000;
        end else begin
            last_r  <= last_nxt;
            edges_o <= edges_nxt;
        end
    end
endmodule // irq_sink_model

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "event_irq_regs.svh"

module tb_top;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic        mclk_i      = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic        wr_i        = 1'b0;
    logic        rd_i        = 1'b0;
    logic [11:0] addr_i      = 12'h000;
    logic [31:0] wdata_i     = 32'h00000000;
    logic [15:0] task_trig_i = 16'h0000;
    logic [31:0] rdata_o;
    logic [31:0] rd_v;
    logic [15:0] event_pulse_o;
    logic [15:0] edges;
    logic        irq_o;
    int          bad_count   = 0;
    int          checks_done = 0;
    int          exp_edges   = 0;

    // Clock of 100 ns period.
    always #50 mclk_i = ~mclk_i;

    event_irq_enable_mask event_irq_enable_mask_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .task_trig_i(task_trig_i), .event_pulse_o(event_pulse_o),
        .irq_o(irq_o));

    irq_sink_model irq_sink_model_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .irq_i(irq_o),
        .edges_o(edges));

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks_done %0d bad_count %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Sample one settled moment after the next edge.
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [11:0] a);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        rd_v = rdata_o;
    endtask

    // Hardware trigger of task n; the event pulse stands for one cycle,
    // in the same cycle as the new flag, and the line follows a cycle on.
    task automatic hw_trig(input int n, input logic en);
        @(posedge mclk_i);
        task_trig_i <= 16'h0001 << n;
        @(posedge mclk_i);
        task_trig_i <= 16'h0000;
        #1;
        chk(event_pulse_o, 32'h00000001 << n);
        chk(irq_o, 1'b0);
        step();
        chk(event_pulse_o, 32'h00000000);
        chk(irq_o, en);
    endtask

    // Clearing the flag drops the line after its one standing cycle.
    task automatic clr_flag(input int n);
        wr(`OFS_EVT_STATUS, 32'h00000001 << n);
        step();
        step();
        chk(irq_o, 1'b0);
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        rd(`OFS_EN_DIRECT);
        chk(rd_v, `RST_ENABLE);
        rd(`OFS_EN_SET);
        chk(rd_v, `RST_ENABLE);
        rd(`OFS_EN_CLEAR);
        chk(rd_v, `RST_ENABLE);
        chk(irq_o, 1'b0);
    endtask

    task automatic t_views();
        wr(`OFS_EN_DIRECT, 32'hFFFFA5A5);
        rd(`OFS_EN_DIRECT);
        chk(rd_v, 32'h0000A5A5);
        rd(`OFS_EN_SET);
        chk(rd_v, 32'h0000A5A5);
        rd(`OFS_EN_CLEAR);
        chk(rd_v, 32'h0000A5A5);
        wr(`OFS_EN_SET, 32'h00000102);
        rd(`OFS_EN_DIRECT);
        chk(rd_v, 32'h0000A5A7);
        wr(`OFS_EN_CLEAR, 32'h00008001);
        rd(`OFS_EN_SET);
        chk(rd_v, 32'h000025A6);
        wr(`OFS_EN_CLEAR, 32'hFFFFFFFF);
        rd(`OFS_EN_CLEAR);
        chk(rd_v, 32'h00000000);
    endtask

    // Every index, once enabled alone and once masked alone.
    task automatic t_gate();
        for (int n = 0; n < 16; n++) begin
            wr(`OFS_EN_DIRECT, 32'h00000001 << n);
            hw_trig(n, 1'b1);
            exp_edges++;
            clr_flag(n);
            wr(`OFS_EN_DIRECT, 32'h0000FFFF ^ (32'h00000001 << n));
            hw_trig(n, 1'b0);
            clr_flag(n);
        end
    endtask

    // A pending masked flag fires once the set view enables it.
    task automatic t_late();
        wr(`OFS_EN_DIRECT, 32'h00000000);
        wr(12'h03C, 32'h00000001);
        rd(12'h13C);
        chk(rd_v, 32'h00000001);
        chk(irq_o, 1'b0);
        wr(`OFS_EN_SET, 32'h00008000);
        #1;
        chk(irq_o, 1'b0);
        step();
        chk(irq_o, 1'b1);
        exp_edges++;
        wr(`OFS_EN_CLEAR, 32'h00008000);
        step();
        step();
        chk(irq_o, 1'b0);
        rd(`OFS_EVT_STATUS);
        chk(rd_v, 32'h00008000);
        wr(12'h13C, 32'h00000001);
        rd(`OFS_EVT_STATUS);
        chk(rd_v, 32'h00000000);
        clr_flag(15);
    endtask

    // A clear landing with a trigger of the same flag loses to it, so
    // no event is dropped; the mask is all zero here, the line stays low.
    task automatic t_race();
        @(posedge mclk_i);
        wr_i        <= 1'b1;
        addr_i      <= `OFS_EVT_STATUS;
        wdata_i     <= 32'h00000001;
        task_trig_i <= 16'h0001;
        @(posedge mclk_i);
        wr_i        <= 1'b0;
        task_trig_i <= 16'h0000;
        rd(`OFS_EVT_STATUS);
        chk(rd_v, 32'h00000001);
        clr_flag(0);
        rd(`OFS_EVT_STATUS);
        chk(rd_v, 32'h00000000);
    endtask

    // An unmapped place reads as zero; a misaligned write leaves the mask alone.
    task automatic t_refuse();
        rd(12'h3F0);
        chk(rd_v, 32'h00000000);
        wr(12'h302, 32'h0000FFFF);
        rd(`OFS_EN_DIRECT);
        chk(rd_v, 32'h00000000);
        chk(edges, exp_edges);
    endtask

    // -----------------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_views();
        t_gate();
        t_late();
        t_race();
        t_refuse();
        close_out();
    end

    // A hang counts as a mismatch and still reaches the verdict.
    initial begin
        #5000000;
        bad_count++;
        close_out();
    end
endmodule // tb_top
